// ===== rtl/safety_check_ctrl.sv
// Purpose: safety check control and processor error-signal phase limits
// Assumes: state, locks and fail counts come from logic on the same clock
// Notes:   only the processor error pin is asynchronous
//
// Functional notes
// - checksum over configuration runs continuously while its enable is one
// - drive enable bit clears when the device enters SAFE
// - drive pin held low while drive enable is zero
// - pin high only in ACTIVE or DIAGNOSTIC with fail counts under limits
// - monitor enable bit switches the error monitor, resets to zero
// - leave request set only by a write while in DIAGNOSTIC
// - leave request clears on any exit from DIAGNOSTIC
// - request set and block clear moves DIAGNOSTIC to ACTIVE
// - high phase maximum is (limit+1) times 15 us in PWM mode
// - high phase minimum is (limit+1) times 15 us in PWM mode
// - limit writes only in DIAGNOSTIC with config lock clear
// - low phase maximum is (limit+1) times 15 us, or 5 us alternate
`timescale 1ns/100ps
module safety_check_ctrl
    import safety_check_pkg::*;
(
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    input  wire reg_cmd_s     i_reg_cmd,
    input  wire logic [1:0]   i_reg_rd_sel,
    input  wire logic         i_ctrl_lock,
    input  wire logic         i_cfg_lock,
    input  wire dev_state_e   i_dev_state,
    input  wire logic         i_diagnostic_leave_block,
    input  wire fail_counts_s i_fail_counts,
    input  wire logic         i_error_monitor_mode_select,
    input  wire logic [7:0]   i_expected_config_checksum,
    input  wire logic         i_processor_error,
    output logic [7:0]        o_reg_rdata,
    output logic              o_enable_drive_pin,
    output logic              o_error_monitor_enable,
    output logic              o_leave_diagnostic,
    output logic              o_crc_active,
    output logic              o_crc_error,
    output logic              o_esm_error
);

    logic [7:0]  control;
    logic [7:0]  high_max;
    logic [7:0]  high_min;
    logic [7:0]  low_max;
    dev_state_e  prev_state;
    logic        enter_safe;
    logic        leave_diag;
    logic        in_diag;
    logic        cfg_open;
    logic [1:0]  crc_idx;
    logic [7:0]  crc_acc;
    logic [7:0]  next_crc;
    logic        err_meta;
    logic        err_sync;
    logic        err_prev;
    logic [10:0] unit_cnt;
    logic [10:0] unit_len;
    logic [8:0]  ticks;
    logic        over_seen;
    logic        pwm_mode;
    logic        edge_seen;
    logic        drive_ok;
    logic        phase_over;

    function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                             input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC8_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [7:0] reg_value(input logic [1:0] sel);
        case (sel)
            SEL_CONTROL:  reg_value = control & CONTROL_WMASK;
            SEL_HIGH_MAX: reg_value = high_max;
            SEL_HIGH_MIN: reg_value = high_min;
            default:      reg_value = low_max;
        endcase
    endfunction

    function automatic logic [8:0] limit_ticks(input logic [7:0] lim);
        return {1'b0, lim} + 9'h001;
    endfunction

    assign in_diag    = (i_dev_state == ST_DIAGNOSTIC);
    assign cfg_open   = in_diag && !i_cfg_lock;
    assign enter_safe = (i_dev_state == ST_SAFE) && (prev_state != ST_SAFE);
    assign leave_diag = (prev_state == ST_DIAGNOSTIC) && !in_diag;
    assign pwm_mode   = i_error_monitor_mode_select;
    assign unit_len   = pwm_mode ? PWM_UNIT_CYC : ALT_UNIT_CYC;
    assign edge_seen  = err_sync != err_prev;
    assign next_crc   = crc8_step(crc_acc, reg_value(crc_idx));
    assign phase_over = err_sync
        ? (pwm_mode && ticks == limit_ticks(high_max))
        : (ticks == limit_ticks(low_max));
    assign drive_ok   = control[BIT_DRIVE_EN]
        && (i_dev_state == ST_ACTIVE || in_diag)
        && (i_fail_counts.watchdog_fail_count
            < i_fail_counts.watchdog_fail_drive_threshold)
        && (i_fail_counts.watchdog_fail_count
            < i_fail_counts.watchdog_fail_reset_threshold)
        && (i_fail_counts.error_monitor_fail_count
            < i_fail_counts.error_monitor_fail_drive_threshold);

    // state history for entry and exit detection
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_state <= ST_OFF;
        end else begin
            prev_state <= i_dev_state;
        end
    end

    // control register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            control <= CONTROL_RESET;
        end else begin
            if (i_reg_cmd.wr && i_reg_cmd.sel == SEL_CONTROL
                    && !i_ctrl_lock) begin
                control[BIT_CRC_EN]   <= i_reg_cmd.wdata[BIT_CRC_EN];
                control[BIT_DRIVE_EN] <= i_reg_cmd.wdata[BIT_DRIVE_EN];
                control[BIT_MON_EN]   <= i_reg_cmd.wdata[BIT_MON_EN];
                if (in_diag || !i_reg_cmd.wdata[BIT_LEAVE_REQ]) begin
                    control[BIT_LEAVE_REQ] <=
                        i_reg_cmd.wdata[BIT_LEAVE_REQ];
                end
            end
            if (enter_safe) begin
                control[BIT_DRIVE_EN] <= 1'b0;
            end
            if (leave_diag) begin
                control[BIT_LEAVE_REQ] <= 1'b0;
            end
        end
    end

    // phase-limit registers
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            high_max <= HIGH_MAX_RESET;
            high_min <= HIGH_MIN_RESET;
            low_max  <= LOW_MAX_RESET;
        end else if (i_reg_cmd.wr && cfg_open) begin
            case (i_reg_cmd.sel)
                SEL_HIGH_MAX: high_max <= i_reg_cmd.wdata;
                SEL_HIGH_MIN: high_min <= i_reg_cmd.wdata;
                SEL_LOW_MAX:  low_max  <= i_reg_cmd.wdata;
                default:      ;
            endcase
        end
    end

    // read data
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= reg_value(i_reg_rd_sel);
        end
    end

    // drive pin and status outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_enable_drive_pin     <= 1'b0;
            o_error_monitor_enable <= 1'b0;
            o_leave_diagnostic     <= 1'b0;
        end else begin
            o_enable_drive_pin     <= drive_ok;
            o_error_monitor_enable <= control[BIT_MON_EN];
            o_leave_diagnostic     <= control[BIT_LEAVE_REQ]
                && !i_diagnostic_leave_block && in_diag;
        end
    end

    // continuous checksum walk over the configuration bytes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_idx      <= 2'h0;
            crc_acc      <= CRC8_INIT;
            o_crc_active <= 1'b0;
            o_crc_error  <= 1'b0;
        end else if (!control[BIT_CRC_EN]) begin
            crc_idx      <= 2'h0;
            crc_acc      <= CRC8_INIT;
            o_crc_active <= 1'b0;
            o_crc_error  <= 1'b0;
        end else begin
            o_crc_active <= 1'b1;
            crc_idx      <= crc_idx + 2'h1;
            if (crc_idx == CRC_LAST) begin
                crc_acc     <= CRC8_INIT;
                o_crc_error <= next_crc != i_expected_config_checksum;
            end else begin
                crc_acc <= next_crc;
            end
        end
    end

    // error pin synchroniser
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_meta <= 1'b0;
            err_sync <= 1'b0;
            err_prev <= 1'b0;
        end else begin
            err_meta <= i_processor_error;
            err_sync <= err_meta;
            err_prev <= err_sync;
        end
    end

    // phase timer in units of 15 us or 5 us
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unit_cnt  <= 11'h000;
            ticks     <= 9'h000;
            over_seen <= 1'b0;
        end else if (!control[BIT_MON_EN] || edge_seen) begin
            unit_cnt  <= 11'h000;
            ticks     <= 9'h000;
            over_seen <= 1'b0;
        end else begin
            if (unit_cnt >= unit_len - 11'h001) begin
                unit_cnt <= 11'h000;
                if (ticks != TICK_SAT) begin
                    ticks <= ticks + 9'h001;
                end
            end else begin
                unit_cnt <= unit_cnt + 11'h001;
            end
            if (phase_over) begin
                over_seen <= 1'b1;
            end
        end
    end

    // phase checks against the limits
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_esm_error <= 1'b0;
        end else if (!control[BIT_MON_EN]) begin
            o_esm_error <= 1'b0;
        end else if (edge_seen) begin
            o_esm_error <= pwm_mode && err_prev
                && ticks < limit_ticks(high_min);
        end else if (over_seen) begin
            o_esm_error <= 1'b0;
        end else begin
            o_esm_error <= phase_over;
        end
    end

    crc_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !control[BIT_CRC_EN] |=> !o_crc_active && !o_crc_error)
        else $error("checksum active while disabled");

    safe_clear_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        enter_safe |=> !control[BIT_DRIVE_EN] ##1 !o_enable_drive_pin)
        else $error("drive enable not cleared on entering safe");

    pin_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !control[BIT_DRIVE_EN] |=> !o_enable_drive_pin)
        else $error("drive pin high while disabled");

    pin_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_enable_drive_pin |-> $past(i_dev_state) == ST_ACTIVE
            || $past(i_dev_state) == ST_DIAGNOSTIC)
        else $error("drive pin high outside active or diagnostic");

    monitor_off_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        !control[BIT_MON_EN] |=> !o_esm_error ##1 !o_error_monitor_enable
            || control[BIT_MON_EN])
        else $error("monitor acting while disabled");

    leave_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !control[BIT_LEAVE_REQ] && !in_diag |=> !control[BIT_LEAVE_REQ])
        else $error("leave request set outside diagnostic");

    leave_clear_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        leave_diag |=> !control[BIT_LEAVE_REQ])
        else $error("leave request kept after leaving diagnostic");

    leave_go_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        control[BIT_LEAVE_REQ] && !i_diagnostic_leave_block && in_diag
            |=> o_leave_diagnostic)
        else $error("leave not signalled");

    limit_lock_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        !cfg_open |=> $stable(high_max) && $stable(high_min)
            && $stable(low_max))
        else $error("limit changed while locked");

    reserved_zero_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        i_reg_rd_sel == SEL_CONTROL |=> (o_reg_rdata & ~CONTROL_WMASK)
            == 8'h00)
        else $error("reserved control bit read as one");

endmodule

// ===== rtl/safety_check_pkg.sv
// Purpose: constants and types for the safety check register block
// Assumes: 100 MHz reference clock
// Notes:   register select codes and checksum polynomial are local picks
package safety_check_pkg;

    // register select codes on the command port
    localparam logic [1:0] SEL_CONTROL  = 2'h0;
    localparam logic [1:0] SEL_HIGH_MAX = 2'h1;
    localparam logic [1:0] SEL_HIGH_MIN = 2'h2;
    localparam logic [1:0] SEL_LOW_MAX  = 2'h3;

    // control register fields
    localparam int BIT_CRC_EN    = 4;
    localparam int BIT_DRIVE_EN  = 3;
    localparam int BIT_MON_EN    = 2;
    localparam int BIT_LEAVE_REQ = 0;
    localparam logic [7:0] CONTROL_WMASK = 8'h1d;

    // reset values
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] HIGH_MAX_RESET = 8'ha8;
    localparam logic [7:0] HIGH_MIN_RESET = 8'ha7;
    localparam logic [7:0] LOW_MAX_RESET  = 8'h3d;

    // checksum engine
    localparam logic [7:0] CRC8_POLY = 8'h2f;
    localparam logic [7:0] CRC8_INIT = 8'hff;
    localparam logic [1:0] CRC_LAST  = 2'h3;

    // phase timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWM_UNIT_US   = 15;
    localparam int ALT_UNIT_US   = 5;
    localparam logic [10:0] PWM_UNIT_CYC =
        11'((PWM_UNIT_US * 1000) / CLK_PERIOD_NS);
    localparam logic [10:0] ALT_UNIT_CYC =
        11'((ALT_UNIT_US * 1000) / CLK_PERIOD_NS);
    localparam logic [8:0] TICK_SAT = 9'h1ff;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_INIT,
        ST_DIAGNOSTIC,
        ST_ACTIVE,
        ST_SAFE
    } dev_state_e;

    typedef struct packed {
        logic       wr;
        logic [1:0] sel;
        logic [7:0] wdata;
    } reg_cmd_s;

    typedef struct packed {
        logic [3:0] watchdog_fail_count;
        logic [3:0] watchdog_fail_drive_threshold;
        logic [3:0] watchdog_fail_reset_threshold;
        logic [3:0] error_monitor_fail_count;
        logic [3:0] error_monitor_fail_drive_threshold;
    } fail_counts_s;

endpackage

// ===== sim/mcu_error_model.sv
// Purpose: processor side model driving the error pin in phases
// Assumes: bench pulses i_go for one cycle per high/low period
// Notes:   pin rests low between periods, as a released error line
`timescale 1ns/100ps
module mcu_error_model (
    input  wire logic i_ref_clk,
    input  wire logic i_go,
    input  wire logic [31:0] i_high_cyc,
    input  wire logic [31:0] i_low_cyc,
    output logic             o_processor_error
);
    // one high phase then one low phase per request
    initial begin
        o_processor_error = 1'b0;
        forever begin
            @(posedge i_ref_clk iff i_go);
            #1 o_processor_error = 1'b1;
            repeat (i_high_cyc) @(posedge i_ref_clk);
            #1 o_processor_error = 1'b0;
            repeat (i_low_cyc) @(posedge i_ref_clk);
        end
    end
endmodule

// ===== sim/safety_check_ctrl_tb_top.sv
// Purpose: self-checking bench for the safety check register block
// Assumes: select codes and state encoding from the package
// Notes:   error pin traffic comes from the processor model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module safety_check_ctrl_tb_top import safety_check_pkg::*;;
    logic         i_ref_clk   = 1'b0;
    logic         i_rst_n     = 1'b0;
    reg_cmd_s     cmd         = '0;
    logic [1:0]   rd_sel      = SEL_CONTROL;
    logic         ctrl_lock   = 1'b0;
    logic         cfg_lock    = 1'b0;
    logic         leave_block = 1'b1;
    dev_state_e   state       = ST_DIAGNOSTIC;
    fail_counts_s fc          = '0;
    logic         pwm_mode    = 1'b1;
    logic [7:0]   exp_crc     = 8'h00;
    logic         go          = 1'b0;
    int           high_cyc    = 0;
    int           low_cyc     = 0;
    int           n_mismatch  = 0;
    int           n_checks    = 0;
    int           cycles      = 0;
    int           hits[$];
    logic         pin;
    logic [7:0]   rdata;
    logic         drive_pin, mon_en, leave, crc_act, crc_err, esm_err;

    safety_check_ctrl safety_check_ctrl_i (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_cmd(cmd),
        .i_reg_rd_sel(rd_sel), .i_ctrl_lock(ctrl_lock),
        .i_cfg_lock(cfg_lock), .i_dev_state(state),
        .i_diagnostic_leave_block(leave_block), .i_fail_counts(fc),
        .i_error_monitor_mode_select(pwm_mode),
        .i_expected_config_checksum(exp_crc), .i_processor_error(pin),
        .o_reg_rdata(rdata), .o_enable_drive_pin(drive_pin),
        .o_error_monitor_enable(mon_en), .o_leave_diagnostic(leave),
        .o_crc_active(crc_act), .o_crc_error(crc_err),
        .o_esm_error(esm_err));

    mcu_error_model mcu_error_model_i (
        .i_ref_clk(i_ref_clk), .i_go(go), .i_high_cyc(high_cyc),
        .i_low_cyc(low_cyc), .o_processor_error(pin));

    always #5 i_ref_clk = ~i_ref_clk;

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        cmd = '{1'b1, s, d};
        step(1);
        cmd.wr = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        rd_sel = s;
        step(1);
        `CHK("rdata", e, rdata)
    endtask

    task automatic drv(input logic [3:0] wd, error_signal_monitor, input logic e);
        fc.watchdog_fail_count = wd;
        fc.error_monitor_fail_count = error_signal_monitor;
        step(2);
        `CHK("drive_pin", e, drive_pin)
    endtask

    task automatic pin_run(input int h, l, n, e0, e1);
        hits.delete();
        high_cyc = h;
        low_cyc = l;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (int i = 1; i <= h + l; i++) begin
            step(1);
            if (esm_err === 1'b1)
                hits.push_back(i);
        end
        `CHK("esm_count", n, hits.size())
        if (n > 0) `CHK("esm_at0", 1'b1, hits[0] >= e0 && hits[0] <= e0 + 8)
        if (n > 1) `CHK("esm_at1", 1'b1, hits[1] >= e1 && hits[1] <= e1 + 8)
    endtask

    task automatic ctrl_bits();
        ctrl_lock = 1'b1;
        wr(SEL_CONTROL, 8'hff);
        rd(SEL_CONTROL, 8'h00);
        ctrl_lock = 1'b0;
        wr(SEL_CONTROL, 8'he6);
        rd(SEL_CONTROL, 8'h04);
        `CHK("mon_en", 1'b1, mon_en)
        wr(SEL_CONTROL, 8'h01);
        rd(SEL_CONTROL, 8'h01);
        `CHK("leave", 1'b0, leave)
        leave_block = 1'b0;
        step(1);
        `CHK("leave", 1'b1, leave)
        state = ST_ACTIVE;
        step(2);
        rd(SEL_CONTROL, 8'h00);
        `CHK("leave", 1'b0, leave)
        wr(SEL_CONTROL, 8'h05);
        rd(SEL_CONTROL, 8'h04);
    endtask

    task automatic drive_checks();
        fc = '{4'h0, 4'h5, 4'h6, 4'h0, 4'h3};
        wr(SEL_CONTROL, 8'h08);
        for (int s = 0; s < 4; s++) begin
            state = dev_state_e'(s);
            drv(4'h0, 4'h0, s >= 2);
        end
        drv(4'h4, 4'h2, 1'b1);
        drv(4'h5, 4'h0, 1'b0);
        drv(4'h0, 4'h3, 1'b0);
        fc.watchdog_fail_drive_threshold = 4'h6;
        fc.watchdog_fail_reset_threshold = 4'h5;
        drv(4'h5, 4'h0, 1'b0);
        drv(4'h4, 4'h2, 1'b1);
        state = ST_SAFE;
        step(2);
        rd(SEL_CONTROL, 8'h00);
        state = ST_ACTIVE;
        drv(4'h0, 4'h0, 1'b0);
    endtask

    task automatic limit_checks();
        wr(SEL_HIGH_MAX, 8'h01);
        rd(SEL_HIGH_MAX, 8'ha8);
        state = ST_DIAGNOSTIC;
        cfg_lock = 1'b1;
        wr(SEL_LOW_MAX, 8'h03);
        rd(SEL_LOW_MAX, 8'h3d);
        cfg_lock = 1'b0;
        wr(SEL_HIGH_MAX, 8'h01);
        wr(SEL_HIGH_MIN, 8'h00);
        wr(SEL_LOW_MAX, 8'h03);
        rd(SEL_HIGH_MAX, 8'h01);
        rd(SEL_HIGH_MIN, 8'h00);
        rd(SEL_LOW_MAX, 8'h03);
    endtask

    // crc8 over control, high max, high min, low max, msb first
    function automatic logic [7:0] crc_of(input logic [31:0] b);
        logic [7:0] c;
        c = CRC8_INIT;
        for (int k = 3; k >= 0; k--) begin
            c = c ^ b[8*k +: 8];
            for (int i = 0; i < 8; i++)
                c = c[7] ? 8'((c << 1) ^ CRC8_POLY) : 8'(c << 1);
        end
        return c;
    endfunction

    task automatic crc_checks();
        exp_crc = crc_of({8'h10, 8'h01, 8'h00, 8'h03});
        wr(SEL_CONTROL, 8'h10);
        `CHK("crc_act", 1'b1, crc_act)
        step(9);
        `CHK("crc_act", 1'b1, crc_act)
        `CHK("crc_err", 1'b0, crc_err)
        exp_crc = ~exp_crc;
        step(5);
        `CHK("crc_err", 1'b1, crc_err)
        wr(SEL_CONTROL, 8'h00);
        `CHK("crc_act", 1'b0, crc_act)
        `CHK("crc_err", 1'b0, crc_err)
    endtask

    task automatic monitor_checks();
        wr(SEL_CONTROL, 8'h04);
        pin_run(3200, 7000, 2, 3000, 9200);
        pin_run(500, 600, 1, 500, 0);
        pwm_mode = 1'b0;
        pin_run(100, 2200, 1, 2100, 0);
        wr(SEL_CONTROL, 8'h00);
        `CHK("mon_en", 1'b0, mon_en)
        pwm_mode = 1'b1;
        pin_run(3200, 100, 0, 0, 0);
    endtask

    initial begin
        step(4);
        i_rst_n = 1'b1;
        rd(SEL_CONTROL, 8'h00);
        rd(SEL_HIGH_MAX, 8'ha8);
        rd(SEL_HIGH_MIN, 8'ha7);
        rd(SEL_LOW_MAX, 8'h3d);
        ctrl_bits();
        drive_checks();
        limit_checks();
        crc_checks();
        monitor_checks();
        print_verdict();
    end
endmodule
